// *** bench/tcmp_mem_model.sv ***
// tcmp_mem_model: behavioural data memory beside the port, 16 words deep.
// assumes fields launch from the rising edge of clk; slow adds one wait cycle.
`timescale 1ns/100ps
module tcmp_mem_model (
  // clock
  input wire logic clk,
  // memory side
  input wire logic cs,
  input wire logic [17:0] addr,
  input wire logic dir,
  input wire logic [3:0] lanes,
  input wire logic [31:0] wdata,
  output logic [31:0] rdata,
  output logic stall,
  // test control
  input wire logic slow
);
  logic [31:0] mem [16];
  logic init_r = 1'b0;
  logic act_r = 1'b0;
  logic stall_r = 1'b0;
  logic [31:0] word;
  assign word = mem[addr[3:0]];
  assign stall = stall_r;
  // inverted word outside served cycles, so a stale sample is caught
  assign rdata = (act_r && !stall_r) ? word : ~word;
  // one process owns the array; cleared on the first edge, long before reset ends
  always @(posedge clk) begin
    init_r <= 1'b1;
    act_r <= cs || (act_r && stall_r);
    stall_r <= slow && cs;
    if (!init_r) begin
      for (int i = 0; i < 16; i++)
        mem[i] <= 32'h0;
    end else if (act_r && !stall_r && dir) begin
      for (int b = 0; b < 4; b++)
        if (lanes[b])
          mem[addr[3:0]][8*b+:8] <= wdata[8*b+:8];
    end
  end
endmodule

// *** bench/test_tcmp_port.sv ***
// test_tcmp_port: random and corner traffic through the port to the memory model.
// assumes the model answers within two cycles; inputs change at the falling edge.
`timescale 1ns/100ps
module test_tcmp_port;
  logic clk = 1'b0;
  logic rstn, dready, drvalid, ivalid, boot, vsel, imem_en, boot_imem, cs, dma_en;
  logic dma_sel, idle, dir, seq, stall, slow, ics, prev_ok;
  logic [31:0] drdata, iaddr, vbase, rdata, wdata;
  logic [17:0] waddr, dma_addr, iwaddr, prev_w;
  logic [3:0] size_cfg, lanes;
  tcmp_pkg::tcmp_req_s req;
  logic [31:0] shadow [16];
  int seed = 88;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  tcmp_port tcmp_port_inst (.CLK(clk), .RSTN(rstn), .CPU_DREQ(req), .CPU_DREADY(dready),
    .CPU_DRDATA(drdata), .CPU_DRVALID(drvalid), .CPU_IREQ_VALID(ivalid), .CPU_IREQ_ADDR(iaddr),
    .IMEM_BOOT_ENABLE(boot), .VECTOR_BASE_SELECT(vsel), .RESET_VECTOR_BASE(vbase),
    .IMEM_ENABLED(imem_en), .BOOT_FROM_IMEM(boot_imem), .DMEM_WORD_ADDR(waddr),
    .DMEM_CHIP_SEL(cs), .DMEM_EXT_DMA_ADDR(dma_addr), .DMEM_EXT_DMA_EN(dma_en),
    .DMEM_EXT_DMA_SEL(dma_sel), .DMEM_IDLE_FLAG(idle), .DMEM_DIR(dir), .DMEM_RDATA(rdata),
    .DMEM_SEQ_HINT(seq), .DMEM_SIZE_CFG(size_cfg), .DMEM_STALL_IN(stall),
    .DMEM_LANE_STROBE(lanes), .DMEM_WDATA(wdata), .IMEM_WORD_ADDR(iwaddr), .IMEM_CHIP_SEL(ics));
  tcmp_mem_model tcmp_mem_model_inst (.clk(clk), .cs(cs), .addr(waddr), .dir(dir),
    .lanes(lanes), .wdata(wdata), .rdata(rdata), .stall(stall), .slow(slow));
  always #2.5 clk = ~clk;
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      fail_count++;
      results();
    end
  end
  function automatic logic [3:0] exp_lanes(logic w, tcmp_pkg::tcmp_acc_size_e s, logic [1:0] o);
    return !w ? 4'h0 : s == tcmp_pkg::TCMP_SZ_WORD ? 4'hf :
      s == tcmp_pkg::TCMP_SZ_HALF ? (o[1] ? 4'hc : 4'h3) : 4'h1 << o;
  endfunction
  task automatic access(input logic w, input tcmp_pkg::tcmp_acc_size_e s,
      input logic [19:0] a, input logic [31:0] d);
    logic [3:0] ln;
    int n;
    ln = exp_lanes(w, s, a[1:0]);
    req = '{1'b1, w, s, {12'h0, a}, d};
    #1;
    chk("sel", cs, 1'b1);
    chk("idle", idle, 1'b0);
    @(negedge clk);
    req.valid = 1'b0;
    #1;
    chk("addr", waddr, a[19:2]);
    chk("dir", dir, w);
    chk("lanes", lanes, ln);
    if (w)
      chk("wdata", wdata, d);
    if (prev_ok)
      chk("seq", seq, a[19:2] == prev_w + 18'h1);
    chk("stall", stall, slow);
    prev_w = a[19:2];
    prev_ok = 1'b1;
    if (stall === 1'b1) begin
      @(negedge clk);
      #1;
      chk("hold addr", waddr, a[19:2]);
      chk("hold dir", dir, w);
      chk("hold lanes", lanes, ln);
      if (w)
        chk("hold wdata", wdata, d);
      chk("wait seq", seq, 1'b1);
    end
    for (int b = 0; b < 4; b++)
      if (ln[b])
        shadow[a[5:2]][8*b+:8] = d[8*b+:8];
    n = 0;
    // read data shows one cycle after the unwaited request cycle
    while (!w && drvalid !== 1'b1 && n < 4) begin
      @(negedge clk);
      #1;
      n++;
    end
    if (!w) begin
      chk("rvalid", drvalid, 1'b1);
      chk("rlat", n, 1);
      chk("rdata", drdata, shadow[a[5:2]]);
    end
    @(negedge clk);
  endtask
  task automatic do_reset(input logic b, input logic v);
    rstn = 1'b0;
    boot = b;
    vsel = v;
    repeat (10) @(negedge clk);
    chk("reset", {waddr, dir, lanes, seq, drvalid}, 32'h0);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    chk("vector", vbase, v ? tcmp_pkg::VEC_HIGH : tcmp_pkg::VEC_LOW);
    chk("boot", boot_imem, b && !v);
    chk("imem en", imem_en, b);
    ivalid = 1'b1;
    iaddr = $random(seed);
    #1;
    chk("isel", ics, b);
    @(negedge clk);
    if (b)
      chk("iaddr", iwaddr, iaddr[19:2]);
    ivalid = 1'b0;
    prev_ok = 1'b0;
  endtask
  initial begin
    logic [31:0] r;
    logic [19:0] a;
    tcmp_pkg::tcmp_acc_size_e s;
    logic [3:0] bad_sz [5];
    bad_sz = '{4'h0, 4'h1, 4'h2, 4'hc, 4'hf};
    foreach (shadow[i])
      shadow[i] = 32'h0;
    req = '0;
    {rstn, ivalid, boot, vsel, dma_en, dma_sel, slow, prev_ok} = '0;
    {iaddr, dma_addr, prev_w} = '0;
    size_cfg = 4'hb;
    do_reset(1'b0, 1'b1);
    do_reset(1'b1, 1'b0);
    // absent and reserved sizes refuse the request
    foreach (bad_sz[k]) begin
      size_cfg = bad_sz[k];
      req.valid = 1'b1;
      #1;
      chk("absent", {dready, cs, idle}, 3'b001);
      @(negedge clk);
    end
    req.valid = 1'b0;
    for (int c = 3; c < 12; c++) begin
      size_cfg = c[3:0];
      access(1'b0, tcmp_pkg::TCMP_SZ_WORD, {c[17:0], 2'b00}, 32'h0);
    end
    repeat (80) begin
      r = $random(seed);
      slow = r[3];
      s = r[0] ? tcmp_pkg::TCMP_SZ_WORD :
        r[1] ? tcmp_pkg::TCMP_SZ_HALF : tcmp_pkg::TCMP_SZ_BYTE;
      a = r[2] ? {prev_w + 18'h1, r[5:4]} : 20'($random(seed));
      a[1:0] = s == tcmp_pkg::TCMP_SZ_WORD ? 2'b00 :
        s == tcmp_pkg::TCMP_SZ_HALF ? {a[1], 1'b0} : a[1:0];
      access(r[6], s, a, $random(seed));
    end
    slow = 1'b0;
    dma_en = 1'b1;
    dma_sel = 1'b1;
    dma_addr = 18'($random(seed));
    #1;
    chk("dma addr", waddr, dma_addr);
    chk("dma sel", cs, 1'b1);
    @(negedge clk);
    dma_sel = 1'b0;
    #1;
    chk("dma nosel", cs, 1'b0);
    @(negedge clk);
    // own read while the dma master steers the address
    req = '{1'b1, 1'b0, tcmp_pkg::TCMP_SZ_WORD, 32'h0, 32'h0};
    #1;
    chk("dma own sel", cs, 1'b1);
    @(negedge clk);
    req.valid = 1'b0;
    #1;
    chk("dma own addr", waddr, dma_addr);
    @(negedge clk);
    dma_en = 1'b0;
    prev_ok = 1'b0;
    #1;
    chk("dma rvalid", drvalid, 1'b1);
    chk("dma rdata", drdata, shadow[dma_addr[3:0]]);
    results();
  end
endmodule

// *** src/tcmp_lane_dec.sv ***
// tcmp_lane_dec: byte-lane strobes from access size and byte offset.
// assumes little-endian lane numbering; purely combinational.
`timescale 1ns/100ps
module tcmp_lane_dec (
  // request
  input wire logic write,
  input wire tcmp_pkg::tcmp_acc_size_e size,
  input wire logic [1:0] offset,
  // strobes
  output logic [3:0] lanes
);
  always_comb begin
    lanes = tcmp_pkg::LANE_NONE;
    if (write) begin
      case (size)
        tcmp_pkg::TCMP_SZ_WORD: lanes = tcmp_pkg::LANE_ALL;
        tcmp_pkg::TCMP_SZ_HALF: lanes = offset[1] ? 4'hc : tcmp_pkg::LANE_LO_HALF;
        tcmp_pkg::TCMP_SZ_BYTE: lanes = 4'(tcmp_pkg::LANE_BYTE0 << offset);
        default: lanes = tcmp_pkg::LANE_NONE;
      endcase
    end
  end
endmodule

// *** src/tcmp_pkg.sv ***
// tcmp_pkg: shared constants and carriers for the tightly coupled memory port.
// assumes a single processor clock domain; no register bus.
package tcmp_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int LANE_W = 4;
  localparam int SIZE_W = 4;
  // memory size codes
  localparam logic [3:0] SIZE_ABSENT = 4'h0;
  localparam logic [3:0] SIZE_MIN = 4'h3;
  localparam logic [3:0] SIZE_MAX = 4'hb;
  // direction encoding
  localparam logic DIR_READ = 1'b0;
  localparam logic DIR_WRITE = 1'b1;
  // reset vector bases
  localparam logic [31:0] VEC_LOW = 32'h0000_0000;
  localparam logic [31:0] VEC_HIGH = 32'hffff_0000;
  // reset values and byte-lane masks
  localparam logic [17:0] ADDR_RST = 18'h0_0000;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;
  localparam logic [3:0] LANE_NONE = 4'h0;
  localparam logic [3:0] LANE_ALL = 4'hf;
  localparam logic [3:0] LANE_LO_HALF = 4'h3;
  localparam logic [3:0] LANE_BYTE0 = 4'h1;

  typedef enum logic [1:0] {
    TCMP_SZ_BYTE = 2'b00,
    TCMP_SZ_HALF = 2'b01,
    TCMP_SZ_WORD = 2'b10
  } tcmp_acc_size_e;

  // processor-side request
  typedef struct packed {
    logic valid;
    logic write;
    tcmp_acc_size_e size;
    logic [31:0] byte_addr;
    logic [31:0] wdata;
  } tcmp_req_s;

  // memory-facing request fields
  typedef struct packed {
    logic [17:0] addr;
    logic dir;
    logic [3:0] lanes;
    logic seq;
    logic [31:0] wdata;
  } tcmp_mreq_s;
endpackage

// *** src/tcmp_port.sv ***
// tcmp_port: processor side of the data and instruction tightly coupled memory.
// assumes the memory and dma master share CLK and drive inputs from its rising edge.
`timescale 1ns/100ps
module tcmp_port (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // processor data request
  input wire tcmp_pkg::tcmp_req_s CPU_DREQ,
  output logic CPU_DREADY,
  output logic [31:0] CPU_DRDATA,
  output logic CPU_DRVALID,
  // processor instruction request
  input wire logic CPU_IREQ_VALID,
  input wire logic [31:0] CPU_IREQ_ADDR,
  // boot configuration
  input wire logic IMEM_BOOT_ENABLE,
  input wire logic VECTOR_BASE_SELECT,
  output logic [31:0] RESET_VECTOR_BASE,
  output logic IMEM_ENABLED,
  output logic BOOT_FROM_IMEM,
  // data memory
  output logic [17:0] DMEM_WORD_ADDR,
  output logic DMEM_CHIP_SEL,
  input wire logic [17:0] DMEM_EXT_DMA_ADDR,
  input wire logic DMEM_EXT_DMA_EN,
  input wire logic DMEM_EXT_DMA_SEL,
  output logic DMEM_IDLE_FLAG,
  output logic DMEM_DIR,
  input wire logic [31:0] DMEM_RDATA,
  output logic DMEM_SEQ_HINT,
  input wire logic [3:0] DMEM_SIZE_CFG,
  input wire logic DMEM_STALL_IN,
  output logic [3:0] DMEM_LANE_STROBE,
  output logic [31:0] DMEM_WDATA,
  // instruction memory
  output logic [17:0] IMEM_WORD_ADDR,
  output logic IMEM_CHIP_SEL
);
  // data port state: request issued last cycle, and its fields
  typedef enum logic [1:0] {
    TCMP_ST_IDLE = 2'b00,
    TCMP_ST_REQ = 2'b01,
    TCMP_ST_WAIT = 2'b10
  } tcmp_state_e;

  function automatic logic [17:0] word_of(input logic [31:0] a);
    word_of = a[19:2];
  endfunction

  function automatic logic present(input logic [3:0] sz);
    // reserved codes are treated as absent rather than guessed at
    present = (sz >= tcmp_pkg::SIZE_MIN) && (sz <= tcmp_pkg::SIZE_MAX);
  endfunction

  tcmp_state_e st_r, st_nxt;
  tcmp_pkg::tcmp_mreq_s mreq_r, mreq_nxt;
  logic [17:0] last_addr_r, last_addr_nxt;
  logic have_last_r, have_last_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic pend_read_r, pend_read_nxt;
  logic [17:0] iaddr_r, iaddr_nxt;
  logic boot_en_r, boot_en_nxt;
  logic vec_hi_r, vec_hi_nxt;
  logic boot_seen_r, boot_seen_nxt;
  logic [3:0] lanes;
  logic dpresent;
  logic own_cs;
  logic busy;
  logic stalled;

  assign dpresent = present(DMEM_SIZE_CFG);
  // wait is looked at only in request and wait cycles
  assign busy = (st_r == TCMP_ST_REQ) || (st_r == TCMP_ST_WAIT);
  assign stalled = busy && DMEM_STALL_IN;
  // a new access may launch when the memory is present and the port is free of a stalled one
  assign CPU_DREADY = !stalled && dpresent;
  assign own_cs = CPU_DREQ.valid && CPU_DREADY;

  tcmp_lane_dec u_lane (
    .write(CPU_DREQ.write),
    .size(CPU_DREQ.size),
    .offset(CPU_DREQ.byte_addr[1:0]),
    .lanes(lanes)
  );

  always_comb begin
    st_nxt = st_r;
    mreq_nxt = mreq_r;
    last_addr_nxt = last_addr_r;
    have_last_nxt = have_last_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = 1'b0;
    pend_read_nxt = pend_read_r;
    if (stalled) begin
      st_nxt = TCMP_ST_WAIT;
      mreq_nxt.seq = 1'b1;
    end else begin
      if (busy && pend_read_r) begin
        rdata_nxt = DMEM_RDATA;
        rvalid_nxt = 1'b1;
      end
      if (own_cs) begin
        st_nxt = TCMP_ST_REQ;
        mreq_nxt.addr = word_of(CPU_DREQ.byte_addr);
        mreq_nxt.dir = CPU_DREQ.write ? tcmp_pkg::DIR_WRITE : tcmp_pkg::DIR_READ;
        mreq_nxt.lanes = CPU_DREQ.write ? lanes : tcmp_pkg::LANE_NONE;
        mreq_nxt.wdata = CPU_DREQ.write ? CPU_DREQ.wdata : mreq_r.wdata;
        mreq_nxt.seq = have_last_r &&
          (word_of(CPU_DREQ.byte_addr) == 18'(last_addr_r + 18'h0_0001));
        last_addr_nxt = word_of(CPU_DREQ.byte_addr);
        have_last_nxt = 1'b1;
        pend_read_nxt = !CPU_DREQ.write;
      end else begin
        st_nxt = TCMP_ST_IDLE;
        mreq_nxt.lanes = tcmp_pkg::LANE_NONE;
        mreq_nxt.seq = 1'b0;
        pend_read_nxt = 1'b0;
      end
    end
    // after dma traffic the hint would compare against a stale address
    if (DMEM_EXT_DMA_EN) begin
      have_last_nxt = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_r <= TCMP_ST_IDLE;
      mreq_r <= '{addr: tcmp_pkg::ADDR_RST, dir: tcmp_pkg::DIR_READ,
                  lanes: tcmp_pkg::LANE_NONE, seq: 1'b0, wdata: tcmp_pkg::DATA_RST};
      last_addr_r <= tcmp_pkg::ADDR_RST;
      have_last_r <= 1'b0;
      rdata_r <= tcmp_pkg::DATA_RST;
      rvalid_r <= 1'b0;
      pend_read_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      mreq_r <= mreq_nxt;
      last_addr_r <= last_addr_nxt;
      have_last_r <= have_last_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      pend_read_r <= pend_read_nxt;
    end
  end

  // memory-facing outputs; request fields come from flops
  assign DMEM_WORD_ADDR = DMEM_EXT_DMA_EN ? DMEM_EXT_DMA_ADDR : mreq_r.addr;
  assign DMEM_CHIP_SEL = DMEM_EXT_DMA_EN ? (DMEM_EXT_DMA_SEL | own_cs) : own_cs;
  assign DMEM_IDLE_FLAG = !own_cs;
  assign DMEM_DIR = mreq_r.dir;
  assign DMEM_LANE_STROBE = mreq_r.lanes;
  assign DMEM_SEQ_HINT = mreq_r.seq;
  assign DMEM_WDATA = mreq_r.wdata;
  assign CPU_DRDATA = rdata_r;
  assign CPU_DRVALID = rvalid_r;

  // instruction side and boot straps, caught on the first edge after release
  always_comb begin
    boot_seen_nxt = 1'b1;
    boot_en_nxt = boot_seen_r ? boot_en_r : IMEM_BOOT_ENABLE;
    vec_hi_nxt = boot_seen_r ? vec_hi_r : VECTOR_BASE_SELECT;
    iaddr_nxt = iaddr_r;
    // no instruction-side history: the sequential hint is data side only
    if (CPU_IREQ_VALID && boot_en_r) begin
      iaddr_nxt = word_of(CPU_IREQ_ADDR);
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      boot_seen_r <= 1'b0;
      boot_en_r <= 1'b0;
      vec_hi_r <= 1'b0;
      iaddr_r <= tcmp_pkg::ADDR_RST;
    end else begin
      boot_seen_r <= boot_seen_nxt;
      boot_en_r <= boot_en_nxt;
      vec_hi_r <= vec_hi_nxt;
      iaddr_r <= iaddr_nxt;
    end
  end

  assign IMEM_WORD_ADDR = iaddr_r;
  assign IMEM_CHIP_SEL = CPU_IREQ_VALID && boot_en_r;
  assign IMEM_ENABLED = boot_en_r;
  assign BOOT_FROM_IMEM = boot_en_r && !vec_hi_r;
  assign RESET_VECTOR_BASE = vec_hi_r ? tcmp_pkg::VEC_HIGH : tcmp_pkg::VEC_LOW;

  // checks
  AST_ADDR_CAPTURE: assert property (@(posedge CLK) disable iff (!RSTN)
    own_cs && !DMEM_EXT_DMA_EN ##1 !DMEM_EXT_DMA_EN
      |-> DMEM_WORD_ADDR == $past(CPU_DREQ.byte_addr[19:2]))
    else $error("word address not captured");
  AST_DMA_ADDR: assert property (@(posedge CLK) disable iff (!RSTN)
    DMEM_EXT_DMA_EN |-> DMEM_WORD_ADDR == DMEM_EXT_DMA_ADDR)
    else $error("dma address not routed");
  AST_DMA_CS: assert property (@(posedge CLK) disable iff (!RSTN)
    DMEM_EXT_DMA_EN && DMEM_EXT_DMA_SEL |-> DMEM_CHIP_SEL)
    else $error("dma select lost");
  AST_IDLE: assert property (@(posedge CLK) disable iff (!RSTN)
    !DMEM_EXT_DMA_EN |-> DMEM_IDLE_FLAG != DMEM_CHIP_SEL)
    else $error("idle flag disagrees with select");
  AST_NO_LANE_READ: assert property (@(posedge CLK) disable iff (!RSTN)
    DMEM_DIR == tcmp_pkg::DIR_READ |-> DMEM_LANE_STROBE == tcmp_pkg::LANE_NONE)
    else $error("lanes set on read");
  AST_HOLD_WAIT: assert property (@(posedge CLK) disable iff (!RSTN)
    stalled |=> $stable(mreq_r.addr) && $stable(mreq_r.dir) && $stable(DMEM_WDATA)
      && $stable(DMEM_LANE_STROBE))
    else $error("request changed while waited");
  AST_SEQ_WAIT: assert property (@(posedge CLK) disable iff (!RSTN)
    stalled |=> DMEM_SEQ_HINT)
    else $error("sequential hint dropped in wait");
  AST_RDATA: assert property (@(posedge CLK) disable iff (!RSTN)
    busy && pend_read_r && !DMEM_STALL_IN |=> CPU_DRVALID && CPU_DRDATA == $past(DMEM_RDATA))
    else $error("read data not sampled");
  AST_ABSENT: assert property (@(posedge CLK) disable iff (!RSTN)
    !dpresent && !DMEM_EXT_DMA_EN |-> !DMEM_CHIP_SEL && DMEM_IDLE_FLAG)
    else $error("select on absent memory");
  AST_NO_CS_STALL: assert property (@(posedge CLK) disable iff (!RSTN)
    stalled |-> !own_cs)
    else $error("new access during wait");
  AST_VECTOR: assert property (@(posedge CLK) disable iff (!RSTN)
    boot_seen_r && vec_hi_r |-> RESET_VECTOR_BASE == tcmp_pkg::VEC_HIGH)
    else $error("vector base wrong");

  // capture of request fields one cycle after the take, with same-cycle idle and ready checks
  AST_CS_ANNOUNCE: assert property (@(posedge CLK) disable iff (!RSTN)
    own_cs |=> busy)
    else $error("select without following request cycle");
  AST_IDLE_ACCESS: assert property (@(posedge CLK) disable iff (!RSTN)
    own_cs && !DMEM_EXT_DMA_EN |-> !DMEM_IDLE_FLAG)
    else $error("idle flag high on access");
  AST_DIR_CAPTURE: assert property (@(posedge CLK) disable iff (!RSTN)
    own_cs |=> DMEM_DIR == $past(CPU_DREQ.write))
    else $error("direction not captured");
  AST_LANE_WORD: assert property (@(posedge CLK) disable iff (!RSTN)
    own_cs && CPU_DREQ.write && CPU_DREQ.size == tcmp_pkg::TCMP_SZ_WORD
      |=> DMEM_LANE_STROBE == tcmp_pkg::LANE_ALL)
    else $error("word write lanes wrong");
  AST_LANE_HALF: assert property (@(posedge CLK) disable iff (!RSTN)
    own_cs && CPU_DREQ.write && CPU_DREQ.size == tcmp_pkg::TCMP_SZ_HALF && !CPU_DREQ.byte_addr[1]
      |=> DMEM_LANE_STROBE == tcmp_pkg::LANE_LO_HALF)
    else $error("low half write lanes wrong");
  AST_LANE_BYTE: assert property (@(posedge CLK) disable iff (!RSTN)
    own_cs && CPU_DREQ.write && CPU_DREQ.size == tcmp_pkg::TCMP_SZ_BYTE
      && CPU_DREQ.byte_addr[1:0] == 2'h0 |=> DMEM_LANE_STROBE == tcmp_pkg::LANE_BYTE0)
    else $error("byte write lanes wrong");
  AST_WDATA_CAPTURE: assert property (@(posedge CLK) disable iff (!RSTN)
    own_cs && CPU_DREQ.write |=> DMEM_WDATA == $past(CPU_DREQ.wdata))
    else $error("write data not captured");
  AST_SEQ_CLEAR: assert property (@(posedge CLK) disable iff (!RSTN)
    !stalled && !own_cs |=> !DMEM_SEQ_HINT)
    else $error("sequential hint left set");
  AST_SEQ_FIRST: assert property (@(posedge CLK) disable iff (!RSTN)
    own_cs && !have_last_r |=> !DMEM_SEQ_HINT)
    else $error("sequential hint without history");
  AST_READY_ABSENT: assert property (@(posedge CLK) disable iff (!RSTN)
    !dpresent |-> !CPU_DREADY)
    else $error("ready with absent memory");
  AST_WAIT_IGNORED: assert property (@(posedge CLK) disable iff (!RSTN)
    !busy && DMEM_STALL_IN && dpresent |-> CPU_DREADY)
    else $error("wait honoured outside request cycles");

  // instruction side and straps
  AST_IMEM_OFF: assert property (@(posedge CLK) disable iff (!RSTN)
    !boot_en_r |-> !IMEM_CHIP_SEL)
    else $error("instruction select while disabled");
  AST_IMEM_ADDR: assert property (@(posedge CLK) disable iff (!RSTN)
    IMEM_CHIP_SEL |=> IMEM_WORD_ADDR == $past(CPU_IREQ_ADDR[19:2]))
    else $error("instruction word address not captured");
  AST_STRAP_HOLD: assert property (@(posedge CLK) disable iff (!RSTN)
    boot_seen_r |=> $stable(boot_en_r) && $stable(vec_hi_r))
    else $error("straps changed after capture");
  AST_VECTOR_LOW: assert property (@(posedge CLK) disable iff (!RSTN)
    boot_seen_r && !vec_hi_r |-> RESET_VECTOR_BASE == tcmp_pkg::VEC_LOW)
    else $error("low vector base wrong");
  AST_BOOT_IMEM: assert property (@(posedge CLK) disable iff (!RSTN)
    boot_seen_r && boot_en_r && !vec_hi_r |-> BOOT_FROM_IMEM && IMEM_ENABLED)
    else $error("boot from instruction memory not flagged");

  COV_WRITE: cover property (@(posedge CLK) disable iff (!RSTN) own_cs && CPU_DREQ.write);
  COV_WAITED: cover property (@(posedge CLK) disable iff (!RSTN) stalled ##1 stalled);
  COV_SEQ: cover property (@(posedge CLK) disable iff (!RSTN) DMEM_SEQ_HINT && !stalled);
  COV_DMA: cover property (@(posedge CLK) disable iff (!RSTN) DMEM_EXT_DMA_EN && own_cs);
  COV_READ: cover property (@(posedge CLK) disable iff (!RSTN) CPU_DRVALID);
endmodule
